/* src/ipf_consts.vh */
// constants for the interrupt priority field block
`ifndef IPF_CONSTS_VH
`define IPF_CONSTS_VH
////////////////////////////////////////////////////////////////////////
// register byte offsets
`define IPF_OFF_WORD1     8'h00
`define IPF_OFF_WORD2     8'h04
`define IPF_OFF_WORD3     8'h08
`define IPF_OFF_WORD4     8'h0c
`define IPF_OFF_WORD5     8'h10
`define IPF_OFF_WORD6     8'h14
`define IPF_OFF_STATUS    8'h18
////////////////////////////////////////////////////////////////////////
// implemented field bits of each priority word
`define IPF_MASK_WORD1    16'h7770
`define IPF_MASK_WORD2    16'h7777
`define IPF_MASK_WORD3    16'h0077
`define IPF_MASK_WORD4    16'h7777
`define IPF_MASK_WORD5    16'h7707
`define IPF_MASK_WORD6    16'h7770
// power-on values, every field at level 4
`define IPF_RST_WORD1     16'h4440
`define IPF_RST_WORD2     16'h4444
`define IPF_RST_WORD3     16'h0044
`define IPF_RST_WORD4     16'h4444
`define IPF_RST_WORD5     16'h4404
`define IPF_RST_WORD6     16'h4440
////////////////////////////////////////////////////////////////////////
// field positions inside a word
`define IPF_FLD_W         3
`define IPF_FLD_A         12
`define IPF_FLD_B         8
`define IPF_FLD_C         4
`define IPF_FLD_D         0
`define IPF_NUM_SRC       19
////////////////////////////////////////////////////////////////////////
// status word layout
`define IPF_STAT_VALID    15
`define IPF_STAT_LVL      8
`define IPF_STAT_SRC      0
////////////////////////////////////////////////////////////////////////
// bus answers and decode codes
`define IPF_RESP_OKAY     2'h0
`define IPF_RESP_SLVERR   2'h2
`define IPF_SEL_STATUS    3'h6
`define IPF_SEL_NONE      3'h7
`endif

/* src/ipf_word_reg.v */
// one priority word with masked, byte-strobed write
`timescale 1ns/1ps
`default_nettype none
module ipf_word_reg #(
   parameter [15:0] RESET_VALUE = 16'h0000,
   parameter [15:0] WRITE_MASK  = 16'h0000
) (
   input  wire        clk,          // system clock
   input  wire        sys_rst,      // async reset, high
   input  wire        writeEnable,  // one-cycle write pulse
   input  wire [1:0]  byteStrobe,   // byte lanes of the write
   input  wire [15:0] writeData,    // new word value
   output reg  [15:0] word          // stored word
);
   wire [15:0] laneMask;

   // only implemented field bits in enabled lanes may change
   assign laneMask = WRITE_MASK & {{8{byteStrobe[1]}}, {8{byteStrobe[0]}}};

   // storage, empty bits stay zero forever
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         word <= RESET_VALUE;
      end else if (writeEnable) begin
         word <= (word & ~laneMask) | (writeData & laneMask);
      end
   end
endmodule // ipf_word_reg
`default_nettype wire

/* src/ipf_arbiter.v */
// picks the pending source with the greatest priority level
`timescale 1ns/1ps
`default_nettype none
module ipf_arbiter #(
   parameter NUM_SRC = 19,
   parameter FLD_W   = 3
) (
   input  wire [NUM_SRC*FLD_W-1:0] levels,     // packed levels, source 0 low
   input  wire [NUM_SRC-1:0]       requests,   // pending and enabled
   output reg                      winValid,   // a source wins
   output reg  [4:0]               winSource,  // index of the winner
   output reg  [FLD_W-1:0]         winLevel    // level of the winner
);
   integer i;

   // strict greater-than: ties go to the lowest index, level 0 never wins
   always @* begin
      winValid  = 1'b0;
      winSource = 5'h00;
      winLevel  = {FLD_W{1'b0}};
      for (i = 0; i < NUM_SRC; i = i + 1) begin
         if (requests[i] && (levels[i*FLD_W +: FLD_W] > winLevel)) begin
            winValid  = 1'b1;
            winSource = i[4:0];
            winLevel  = levels[i*FLD_W +: FLD_W];
         end
      end
   end
endmodule // ipf_arbiter
`default_nettype wire

/* src/ipf_top.v */
// priority words one to six with axi4-lite access and arbitration
// How it works
// - a field code of 111 means level 7, the highest a source can have.
// - code 001 is level 1, the lowest active one, and codes between map to the levels between.
// - a field holding 000 disables its source, which then never wins whatever it requests.
// - bit positions without a field read as zero and writes to them are dropped.
// - every field starts at 100 (level 4) after reset, and all fields can be read and written.
// - word one holds timer 2 in bits 14-12, compare 2 in 10-8 and capture 2 in 6-4.
// - word two holds serial 1 receive, spi 1 event, spi 1 fault and timer 3 in 14-12, 10-8, 6-4, 2-0.
// - word three leaves bits 15-7 empty, converter done in 6-4 and serial 1 transmit in 2-0.
// - word four holds pin change, comparator, i2c 1 master and i2c 1 slave in 14-12, 10-8, 6-4, 2-0.
// - word five holds capture 8 in 14-12, capture 7 in 10-8, empty 7-3, external 1 in 2-0.
// - word six holds timer 4 in 14-12, compare 4 in 10-8 and compare 3 in 6-4.
//
// The AXI4-Lite register port and the register addresses were decided locally.

`timescale 1ns/1ps
`default_nettype none
`include "ipf_consts.vh"
module ipf_top #(
   parameter ADDR_W = 8
) (
   input  wire              clk,            // system clock, 10 mhz
   input  wire              sys_rst,        // async reset, high
   // axi4-lite write address
   input  wire [ADDR_W-1:0] s_axi_awaddr,   // write byte address
   input  wire              s_axi_awvalid,  // write address valid
   output reg               s_axi_awready,  // write address taken
   // axi4-lite write data
   input  wire [31:0]       s_axi_wdata,    // write data
   input  wire [3:0]        s_axi_wstrb,    // write byte strobes
   input  wire              s_axi_wvalid,   // write data valid
   output reg               s_axi_wready,   // write data taken
   // axi4-lite write response
   output reg  [1:0]        s_axi_bresp,    // write answer code
   output reg               s_axi_bvalid,   // write answer valid
   input  wire              s_axi_bready,   // master takes answer
   // axi4-lite read address
   input  wire [ADDR_W-1:0] s_axi_araddr,   // read byte address
   input  wire              s_axi_arvalid,  // read address valid
   output reg               s_axi_arready,  // read address taken
   // axi4-lite read data
   output reg  [31:0]       s_axi_rdata,    // read data
   output reg  [1:0]        s_axi_rresp,    // read answer code
   output reg               s_axi_rvalid,   // read data valid
   input  wire              s_axi_rready,   // master takes data
   // interrupt sources and core side
   input  wire [18:0]       srcPending,     // request flags per source
   input  wire [18:0]       srcEnable,      // enable bits per source
   output reg               irqValid,       // a request is offered
   output reg  [4:0]        irqSource,      // index of offered source
   output reg  [2:0]        irqLevel        // level of offered source
);

   ////////////////////////////////////////////////////////////////////
   // register map, byte addresses, address bits 1:0 ignored
   //    00 word one    04 word two    08 word three
   //    0c word four   10 word five   14 word six
   //    18 status, read only, a write is answered okay and dropped
   //    any other address answers slverr, a read returns zero
   // status word
   //    bit 15     a request is offered to the core
   //    bits 10:8  level of the offered request
   //    bits 4:0   index of the offered source
   //    other bits read as zero

   // address decode shared by read and write paths
   function [2:0] wordSelect;
      input [ADDR_W-1:0] addr;
      begin
         case ({addr[ADDR_W-1:2], 2'h0})
            `IPF_OFF_WORD1:  wordSelect = 3'h0;
            `IPF_OFF_WORD2:  wordSelect = 3'h1;
            `IPF_OFF_WORD3:  wordSelect = 3'h2;
            `IPF_OFF_WORD4:  wordSelect = 3'h3;
            `IPF_OFF_WORD5:  wordSelect = 3'h4;
            `IPF_OFF_WORD6:  wordSelect = 3'h5;
            `IPF_OFF_STATUS: wordSelect = `IPF_SEL_STATUS;
            default:         wordSelect = `IPF_SEL_NONE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // per-word reset values and write masks, word one lowest
   localparam [95:0] WORD_RESETS = {`IPF_RST_WORD6, `IPF_RST_WORD5,
                                    `IPF_RST_WORD4, `IPF_RST_WORD3,
                                    `IPF_RST_WORD2, `IPF_RST_WORD1};
   localparam [95:0] WORD_MASKS  = {`IPF_MASK_WORD6, `IPF_MASK_WORD5,
                                    `IPF_MASK_WORD4, `IPF_MASK_WORD3,
                                    `IPF_MASK_WORD2, `IPF_MASK_WORD1};

   ////////////////////////////////////////////////////////////////////
   // declarations
   reg  [ADDR_W-1:0] awAddrHeld;   // captured write address
   reg               awHeld;       // write address waiting
   reg  [15:0]       wDataHeld;    // captured low data half
   reg  [1:0]        wStrbHeld;    // captured low strobes
   reg               wHeld;        // write data waiting
   wire              wrFire;       // both halves present, do write
   wire [2:0]        wrSel;        // decoded write target
   wire [2:0]        rdSel;        // decoded read target
   wire [95:0]       wordBus;      // all six words, word one lowest
   wire [56:0]       levels;       // packed source levels
   wire [18:0]       requests;     // pending and enabled
   wire              winValid;     // arbiter result valid
   wire [4:0]        winSource;    // arbiter winner
   wire [2:0]        winLevel;     // arbiter level
   reg  [15:0]       readWord;     // selected read value

   ////////////////////////////////////////////////////////////////////
   // six priority words
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : gWord
         ipf_word_reg #(
            .RESET_VALUE (WORD_RESETS[16*g +: 16]),
            .WRITE_MASK  (WORD_MASKS[16*g +: 16])
         ) uWord (
            .clk         (clk),
            .sys_rst     (sys_rst),
            .writeEnable (wrFire && (wrSel == g)),
            .byteStrobe  (wStrbHeld),
            .writeData   (wDataHeld),
            .word        (wordBus[16*g +: 16])
         );
      end
   endgenerate
   // reset loads 100 into every field, masks keep empty bits at zero

   ////////////////////////////////////////////////////////////////////
   // write timing: address and data wait once taken; one edge after the
   // later handshake the word is written and bvalid raised; both readies
   // return one edge after the answer is taken, one write at a time

   // write channel capture, address and data in either order
   assign wrFire = awHeld && wHeld && !s_axi_bvalid;
   assign wrSel  = wordSelect(awAddrHeld);

   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         awAddrHeld    <= {ADDR_W{1'b0}};
         awHeld        <= 1'b0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !awHeld && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
         if (s_axi_awvalid && s_axi_awready) begin
            awAddrHeld <= s_axi_awaddr;
            awHeld     <= 1'b1;
         end else if (wrFire) begin
            awHeld     <= 1'b0;
         end
      end
   end

   // data half; only the low two lanes carry field bits
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wDataHeld    <= 16'h0000;
         wStrbHeld    <= 2'h0;
         wHeld        <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !wHeld && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_wvalid && s_axi_wready) begin
            wDataHeld <= s_axi_wdata[15:0];
            wStrbHeld <= s_axi_wstrb[1:0];
            wHeld     <= 1'b1;
         end else if (wrFire) begin
            wHeld     <= 1'b0;
         end
      end
   end

   // write answer, error for an address outside the map
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `IPF_RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wrSel == `IPF_SEL_NONE) ? `IPF_RESP_SLVERR : `IPF_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read path
   assign rdSel = wordSelect(s_axi_araddr);

   // read mux, empty bits come back as zero from the word storage
   always @* begin
      case (rdSel)
         3'h0:            readWord = wordBus[15:0];
         3'h1:            readWord = wordBus[31:16];
         3'h2:            readWord = wordBus[47:32];
         3'h3:            readWord = wordBus[63:48];
         3'h4:            readWord = wordBus[79:64];
         3'h5:            readWord = wordBus[95:80];
         `IPF_SEL_STATUS: begin
            readWord = 16'h0000;
            readWord[`IPF_STAT_VALID] = irqValid;
            readWord[`IPF_STAT_LVL +: 3] = irqLevel;
            readWord[`IPF_STAT_SRC +: 5] = irqSource;
         end
         default:         readWord = 16'h0000;
      endcase
   end

   // read data are latched at the address handshake and stand with
   // rvalid until rready; arready returns one edge after rvalid drops

   // one read at a time, data registered at the address handshake
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `IPF_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, readWord};
            s_axi_rresp  <= (rdSel == `IPF_SEL_NONE) ? `IPF_RESP_SLVERR : `IPF_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // source index: 0 timer 2, 1 compare 2, 2 capture 2, 3 serial 1 receive,
   // 4 spi 1 event, 5 spi 1 fault, 6 timer 3, 7 converter done,
   // 8 serial 1 transmit, 9 pin change, 10 comparator, 11 i2c 1 master,
   // 12 i2c 1 slave, 13 capture 8, 14 capture 7, 15 external 1,
   // 16 timer 4, 17 compare 4, 18 compare 3

   // field extraction, source i sits at levels[3*i +: 3]
   // word one
   assign levels[2:0]   = wordBus[`IPF_FLD_A +: 3];
   assign levels[5:3]   = wordBus[`IPF_FLD_B +: 3];
   assign levels[8:6]   = wordBus[`IPF_FLD_C +: 3];

   // word two
   assign levels[11:9]  = wordBus[16 + `IPF_FLD_A +: 3];
   assign levels[14:12] = wordBus[16 + `IPF_FLD_B +: 3];
   assign levels[17:15] = wordBus[16 + `IPF_FLD_C +: 3];
   assign levels[20:18] = wordBus[16 + `IPF_FLD_D +: 3];

   // word three, upper bits stay empty through its mask
   assign levels[23:21] = wordBus[32 + `IPF_FLD_C +: 3];
   assign levels[26:24] = wordBus[32 + `IPF_FLD_D +: 3];

   // word four
   assign levels[29:27] = wordBus[48 + `IPF_FLD_A +: 3];
   assign levels[32:30] = wordBus[48 + `IPF_FLD_B +: 3];
   assign levels[35:33] = wordBus[48 + `IPF_FLD_C +: 3];
   assign levels[38:36] = wordBus[48 + `IPF_FLD_D +: 3];

   // word five, bits 7-3 empty
   assign levels[41:39] = wordBus[64 + `IPF_FLD_A +: 3];
   assign levels[44:42] = wordBus[64 + `IPF_FLD_B +: 3];
   assign levels[47:45] = wordBus[64 + `IPF_FLD_D +: 3];

   // word six
   assign levels[50:48] = wordBus[80 + `IPF_FLD_A +: 3];
   assign levels[53:51] = wordBus[80 + `IPF_FLD_B +: 3];
   assign levels[56:54] = wordBus[80 + `IPF_FLD_C +: 3];

   ////////////////////////////////////////////////////////////////////
   // arbitration: the code is the level itself, 7 highest, 1 lowest
   assign requests = srcPending & srcEnable;

   ipf_arbiter #(
      .NUM_SRC   (`IPF_NUM_SRC),
      .FLD_W     (`IPF_FLD_W)
   ) uArbiter (
      .levels    (levels),
      .requests  (requests),
      .winValid  (winValid),
      .winSource (winSource),
      .winLevel  (winLevel)
   );

   // the arbiter is combinational and its answer is registered once, so
   // the core sees a new request or level one edge after it appears

   // offered request, registered toward the core
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqValid  <= 1'b0;
         irqSource <= 5'h00;
         irqLevel  <= 3'h0;
      end else begin
         irqValid  <= winValid;
         irqSource <= winSource;
         irqLevel  <= winLevel;
      end
   end
endmodule // ipf_top
`default_nettype wire

/* verification/ipf_top_assertions.sv */
// port checker for the priority word block
`timescale 1ns/1ps
`default_nettype none
module ipf_top_assertions (
   input wire logic        clk,           // system clock
   input wire logic        sys_rst,       // async reset, high
   input wire logic        s_axi_awvalid, // write address valid
   input wire logic        s_axi_awready, // write address taken
   input wire logic        s_axi_wvalid,  // write data valid
   input wire logic        s_axi_wready,  // write data taken
   input wire logic        s_axi_bvalid,  // write answer valid
   input wire logic        s_axi_bready,  // write answer taken
   input wire logic        s_axi_arvalid, // read address valid
   input wire logic        s_axi_arready, // read address taken
   input wire logic [31:0] s_axi_rdata,   // read data
   input wire logic [1:0]  s_axi_rresp,   // read answer code
   input wire logic        s_axi_rvalid,  // read data valid
   input wire logic        s_axi_rready,  // read data taken
   input wire logic [18:0] srcPending,    // request flags
   input wire logic [18:0] srcEnable,     // enable bits
   input wire logic        irqValid,      // request offered
   input wire logic [4:0]  irqSource,     // offered source
   input wire logic [2:0]  irqLevel       // offered level
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////////////////
   // arbitration side
   a_off_never_wins: assert property (irqValid |-> irqLevel != 3'h0)
      else $error("offered request carries level zero");
   a_idle_outputs_zero: assert property (!irqValid |-> irqSource == 5'h00 && irqLevel == 3'h0)
      else $error("idle offer not zero");
   a_no_request_idle: assert property ((srcPending & srcEnable) == 19'h0 |=> !irqValid)
      else $error("offer without any request");
   a_winner_was_pending: assert property (irqValid |-> (($past(srcPending & srcEnable) >> irqSource) & 19'h1) != 19'h0)
      else $error("offered source was not requesting");
   ////////////////////////////////////////////////////////////////////////
   // register bus side
   a_upper_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   a_error_data_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write not answered in time");
   a_write_reopen: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready && s_axi_wready)
      else $error("write channel not reopened");
endmodule // ipf_top_assertions
bind ipf_top ipf_top_assertions ipf_top_assertions_i (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .srcPending, .srcEnable,
   .irqValid, .irqSource, .irqLevel);
`default_nettype wire

/* verification/ipf_src_model.sv */
// model of the interrupt sources that feed the block
`timescale 1ns/1ps
`default_nettype none
module ipf_src_model (
   input wire logic         clk,        // system clock
   input wire logic         sys_rst,    // async reset, high
   input wire logic [18:0]  raise,      // one-cycle request events
   input wire logic [18:0]  clear,      // software clears of flags
   input wire logic [18:0]  enIn,       // wanted enable bits
   output var logic [18:0]  srcPending, // latched request flags
   output var logic [18:0]  srcEnable   // registered enables
);
   // flags stay set until cleared, as real peripherals do
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         srcPending <= 19'h0;
         srcEnable  <= 19'h0;
      end else begin
         srcPending <= (srcPending | raise) & ~clear;
         srcEnable  <= enIn;
      end
   end
endmodule // ipf_src_model
`default_nettype wire

/* verification/ipf_top_tb.sv */
// self-checking bench for the priority word block
`timescale 1ns/1ps
`default_nettype none
`include "ipf_consts.vh"
module ipf_top_tb;
   logic        clk, sys_rst, irqValid, irqChk;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [18:0] srcPending, srcEnable, raise, clear, enIn, pendExp;
   logic [4:0]  irqSource;
   logic [2:0]  irqLevel;
   logic [33:0] rQ[$], bQ[$], iQ[$];
   logic [15:0] sh[6];
   logic [2:0]  lv[19];
   int          failures, checks_done, cyc;
   // source to word and shift tables, then word masks and reset values
   localparam int WD[19] = '{0,0,0,1,1,1,1,2,2,3,3,3,3,4,4,4,5,5,5};
   localparam int SH[19] = '{12,8,4,12,8,4,0,4,0,12,8,4,0,12,8,0,12,8,4};
   localparam logic [15:0] MSK[6] = '{`IPF_MASK_WORD1, `IPF_MASK_WORD2, `IPF_MASK_WORD3,
                                      `IPF_MASK_WORD4, `IPF_MASK_WORD5, `IPF_MASK_WORD6};
   localparam logic [15:0] RST[6] = '{`IPF_RST_WORD1, `IPF_RST_WORD2, `IPF_RST_WORD3,
                                      `IPF_RST_WORD4, `IPF_RST_WORD5, `IPF_RST_WORD6};
   ////////////////////////////////////////////////////////////////////////
   ipf_top ipf_top_i (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .srcPending, .srcEnable, .irqValid, .irqSource, .irqLevel);
   ipf_src_model ipf_src_model_i (.clk, .sys_rst, .raise, .clear, .enIn, .srcPending, .srcEnable);
   ////////////////////////////////////////////////////////////////////////
   // xorshift source for the ignored upper lanes
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bus write: both channels offered together, each released when taken
   task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] s, input logic [1:0] er);
      logic [31:0] r;
      logic dn;
      r = rnd();
      dn = 1'b0;
      bQ.push_back({32'h0, er});
      s_axi_awaddr <= a;
      s_axi_wdata <= {r[31:16], d};
      s_axi_wstrb <= {r[1:0], s};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!dn) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            dn = 1'b1;
         end
      end
      @(posedge clk);
   endtask
   // bus read: data accepted a cycle late so the answer must hold
   task rd(input logic [7:0] a, input logic [33:0] e);
      logic dn;
      dn = 1'b0;
      rQ.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!dn) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rready <= 1'b0;
            dn = 1'b1;
         end
      end
      @(posedge clk);
   endtask
   // set one source field through a full word write
   task fld(input int i, input logic [2:0] c);
      sh[WD[i]] = (sh[WD[i]] & ~(16'h0007 << SH[i])) | (16'(c) << SH[i]);
      lv[i] = c;
      wr(8'(4 * WD[i]), sh[WD[i]], 2'b11, `IPF_RESP_OKAY);
   endtask
   // expected winner: greatest level, lowest index on ties
   task ichk();
      logic [2:0] b;
      logic [4:0] s;
      b = 3'h0;
      s = 5'h00;
      for (int i = 0; i < 19; i++) if (pendExp[i] && enIn[i] && lv[i] > b) begin
         b = lv[i];
         s = 5'(i);
      end
      iQ.push_back({25'h0, b != 3'h0, s, b});
      irqChk <= 1'b1;
      @(posedge clk);
      irqChk <= 1'b0;
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // result watcher and hang limit
   always @(posedge clk) begin
      if (s_axi_rvalid && s_axi_rready) cmp("read", rQ.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready) cmp("bresp", bQ.pop_front(), {32'h0, s_axi_bresp});
      if (irqChk) cmp("irq", iQ.pop_front(), {25'h0, irqValid, irqSource, irqLevel});
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         failures++;
         report_and_stop();
      end
   end
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // main sequence
   initial begin
      {seed, sys_rst, irqChk, failures, checks_done, cyc} = {32'd218, 1'b1, 1'b0, 32'd0, 32'd0, 32'd0};
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {raise, clear, enIn, pendExp} = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 6; k++) rd(8'(4 * k), {18'h0, RST[k]});
      rd(8'h1c, {`IPF_RESP_SLVERR, 32'h0});
      $display("test reset values done");
      for (int k = 0; k < 6; k++) begin
         wr(8'(4 * k), 16'hffff, 2'b11, `IPF_RESP_OKAY);
         rd(8'(4 * k), {18'h0, MSK[k]});
         wr(8'(4 * k), 16'h0000, 2'b01, `IPF_RESP_OKAY);
         rd(8'(4 * k), {18'h0, MSK[k] & 16'hff00});
         wr(8'(4 * k), 16'h0000, 2'b11, `IPF_RESP_OKAY);
         sh[k] = 16'h0;
      end
      wr(8'h1c, 16'hffff, 2'b11, `IPF_RESP_SLVERR);
      $display("test field masks done");
      for (int i = 0; i < 19; i++) lv[i] = 3'h0;
      raise <= 19'h7ffff;
      enIn <= 19'h7ffff;
      pendExp = 19'h7ffff;
      @(posedge clk);
      raise <= 19'h0;
      repeat (3) @(posedge clk);
      ichk();
      for (int i = 0; i < 19; i++) begin
         fld(i, 3'((i % 7) + 1));
         ichk();
      end
      for (int k = 0; k < 6; k++) rd(8'(4 * k), {18'h0, sh[k]});
      wr(`IPF_OFF_STATUS, 16'hffff, 2'b11, `IPF_RESP_OKAY);
      rd(`IPF_OFF_STATUS, {18'h0, (16'h1 << `IPF_STAT_VALID) | (16'h7 << `IPF_STAT_LVL) | (16'h6 << `IPF_STAT_SRC)});
      $display("test arbitration done");
      enIn <= 19'h7ffbf;
      repeat (3) @(posedge clk);
      ichk();
      fld(13, 3'h0);
      ichk();
      clear <= 19'h7ffff;
      pendExp = 19'h0;
      repeat (3) @(posedge clk);
      ichk();
      $display("test masking done");
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(8'h00, {18'h0, RST[0]});
      $display("test second reset done");
      report_and_stop();
   end
endmodule // ipf_top_tb
`default_nettype wire
